// ===== src/vga_hblank_end_hsync_start.sv
`timescale 1ns/1ps
`default_nettype none
`include "hblank_consts.svh"
module vga_hblank_end_hsync_start
   import vga_hblank_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [15:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic      [7:0] io_rdata,
   input  wire logic       color_port_emulation,
   input  wire logic       group_protect,
   input  wire logic [7:0] horiz_total,
   input  wire logic [7:0] display_end,
   input  wire logic [7:0] horiz_blank_start,
   input  wire logic       blank_end_msb,
   input  wire logic [4:0] sync_end_low,
   input  wire skew_t      sync_skew,
   input  wire logic       text_mode,
   output logic            display_enable,
   output logic            hblank,
   output logic            hsync
);
   logic      rst_sync1_q;
   logic      rst_sync2_q;
   logic      rst_n;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end
   assign rst_n = rst_sync2_q;

   // register port
   port_sel_t  port_sel;
   logic [6:0] index_q,  index_d;
   logic [6:0] blank_end_q, blank_end_d;
   logic [7:0] sync_start_q, sync_start_d;
   logic [7:0] rdata_q,  rdata_d;
   logic       wr_blocked;
   logic [7:0] data_read;

   always_comb begin
      port_sel = PORT_NONE;
      if ((color_port_emulation && io_addr == `IO_INDEX_COLOR) ||
          (!color_port_emulation && io_addr == `IO_INDEX_MONO)) begin
         port_sel = PORT_INDEX;
      end else if ((color_port_emulation && io_addr == `IO_DATA_COLOR) ||
                   (!color_port_emulation && io_addr == `IO_DATA_MONO)) begin
         port_sel = PORT_DATA;
      end
   end

   assign wr_blocked = group_protect && (index_q <= `IDX_PROTECT_LAST);

   always_comb begin
      data_read = `BYTE_ZERO;
      if (index_q == `IDX_BLANK_END) begin
         data_read = {1'b1, blank_end_q};
      end else if (index_q == `IDX_SYNC_START) begin
         data_read = sync_start_q;
      end
   end

   always_comb begin
      index_d      = index_q;
      blank_end_d  = blank_end_q;
      sync_start_d = sync_start_q;
      rdata_d      = rdata_q;
      if (io_wr && port_sel == PORT_INDEX) begin
         index_d = io_wdata[6:0];
      end
      if (io_wr && port_sel == PORT_DATA && !wr_blocked) begin
         if (index_q == `IDX_BLANK_END) begin
            blank_end_d = io_wdata[6:0];
         end
         if (index_q == `IDX_SYNC_START) begin
            sync_start_d = io_wdata;
         end
      end
      if (io_rd && port_sel == PORT_INDEX) begin
         rdata_d = {1'b0, index_q};
      end else if (io_rd && port_sel == PORT_DATA) begin
         rdata_d = data_read;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         index_q      <= `IDX_RESET;
         blank_end_q  <= `BLANK_END_RESET;
         sync_start_q <= `SYNC_START_RESET;
         rdata_q      <= `BYTE_ZERO;
      end else begin
         index_q      <= index_d;
         blank_end_q  <= blank_end_d;
         sync_start_q <= sync_start_d;
         rdata_q      <= rdata_d;
      end
   end
   assign io_rdata = rdata_q;

   // horizontal timing
   hcount_t    hcnt_q, hcnt_d;
   logic       blank_q, blank_d;
   logic       sync_q,  sync_d;
   logic [5:0] blank_end_val;
   hcount_t    line_last;
   logic       de_raw;
   logic       sync_raw;
   skew_t      sync_amount;

   assign blank_end_val = {blank_end_msb, blank_end_q[`BLANK_END_LO_HI:0]};
   assign line_last     = {1'b0, horiz_total} + `TOTAL_ADJUST;
   assign de_raw        = (hcnt_q <= {1'b0, display_end});
   // text mode pushes sync one more clock, saturating at three
   assign sync_amount   = (text_mode && sync_skew != 2'h3) ?
                          skew_t'(sync_skew + `TEXT_SYNC_EXTRA) : sync_skew;

   always_comb begin
      hcnt_d  = (hcnt_q >= line_last) ? `HCNT_ZERO : hcount_t'(hcnt_q + `HCNT_ONE);
      blank_d = blank_q;
      sync_d  = sync_q;
      if (blank_q && hcnt_q[5:0] == blank_end_val) begin
         blank_d = 1'b0;
      end else if (hcnt_q == {1'b0, horiz_blank_start}) begin
         blank_d = 1'b1;
      end
      if (hcnt_q == {1'b0, sync_start_q}) begin
         sync_d = 1'b1;
      end else if (sync_q && hcnt_q[4:0] == sync_end_low) begin
         sync_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hcnt_q  <= `HCNT_ZERO;
         blank_q <= 1'b0;
         sync_q  <= 1'b0;
      end else begin
         hcnt_q  <= hcnt_d;
         blank_q <= blank_d;
         sync_q  <= sync_d;
      end
   end
   assign sync_raw = sync_q;
   assign hblank   = blank_q;

   hskew_delay u_de_skew (
      .clk    (clk),
      .rst_n  (rst_n),
      .din    (de_raw),
      .amount (blank_end_q[`SKEW_HI:`SKEW_LO]),
      .dout   (display_enable)
   );

   hskew_delay u_sync_skew (
      .clk    (clk),
      .rst_n  (rst_n),
      .din    (sync_raw),
      .amount (sync_amount),
      .dout   (hsync)
   );

   // checks
   property p_rsvd_reads_one;
      @(posedge clk) disable iff (!rst_n)
      (io_rd && port_sel == PORT_DATA && index_q == `IDX_BLANK_END) |=> io_rdata[7];
   endproperty
   a_rsvd_reads_one: assert property (p_rsvd_reads_one) else $error("bit 7 not one");

   property p_skew_three;
      @(posedge clk) disable iff (!rst_n)
      (blank_end_q[6:5] == 2'b11) [*4] |-> display_enable == $past(de_raw, 3);
   endproperty
   a_skew_three: assert property (p_skew_three) else $error("skew 3 wrong");

   property p_skew_none;
      @(posedge clk) disable iff (!rst_n)
      (blank_end_q[6:5] == 2'b00) |-> display_enable == de_raw;
   endproperty
   a_skew_none: assert property (p_skew_none) else $error("skew 0 wrong");

   property p_blank_end;
      @(posedge clk) disable iff (!rst_n)
      (blank_q && hcnt_q[5:0] == blank_end_val) |=> !hblank;
   endproperty
   a_blank_end: assert property (p_blank_end) else $error("blank did not end");

   property p_blank_end_msb;
      @(posedge clk) disable iff (!rst_n)
      (blank_q && hcnt_q[5:0] != {blank_end_msb, blank_end_q[4:0]}) |=> hblank;
   endproperty
   a_blank_end_msb: assert property (p_blank_end_msb) else $error("end value wrong");

   property p_blank_start;
      @(posedge clk) disable iff (!rst_n)
      (!blank_q && hcnt_q == {1'b0, horiz_blank_start}) |=> hblank;
   endproperty
   a_blank_start: assert property (p_blank_start) else $error("blank did not start");

   property p_sync_start;
      @(posedge clk) disable iff (!rst_n)
      (hcnt_q == {1'b0, sync_start_q} && sync_amount == 2'b00 &&
       $stable(sync_amount)) |=> hsync;
   endproperty
   a_sync_start: assert property (p_sync_start) else $error("sync did not start");

   property p_sync_skew;
      @(posedge clk) disable iff (!rst_n)
      (sync_amount == 2'b10) [*3] |-> hsync == $past(sync_raw, 2);
   endproperty
   a_sync_skew: assert property (p_sync_skew) else $error("sync skew wrong");

   property p_protect;
      @(posedge clk) disable iff (!rst_n)
      (io_wr && port_sel == PORT_DATA && group_protect && index_q == `IDX_SYNC_START)
      |=> $stable(sync_start_q);
   endproperty
   a_protect: assert property (p_protect) else $error("protected write landed");

   property p_sync_write;
      @(posedge clk) disable iff (!rst_n)
      (io_wr && port_sel == PORT_DATA && !group_protect && index_q == `IDX_SYNC_START)
      |=> sync_start_q == $past(io_wdata);
   endproperty
   a_sync_write: assert property (p_sync_write) else $error("sync start not written");

   property p_index_write;
      @(posedge clk) disable iff (!rst_n)
      (io_wr && port_sel == PORT_INDEX) |=> index_q == $past(io_wdata[6:0]);
   endproperty
   a_index_write: assert property (p_index_write) else $error("index not written");

   c_blank_cycle: cover property (@(posedge clk) disable iff (!rst_n) $rose(hblank) ##[1:300] $fell(hblank));
   c_sync_pulse:  cover property (@(posedge clk) disable iff (!rst_n) $rose(hsync) ##[1:300] $fell(hsync));
   c_protected:   cover property (@(posedge clk) disable iff (!rst_n) io_wr && wr_blocked && port_sel == PORT_DATA);
endmodule // vga_hblank_end_hsync_start
`default_nettype wire

// ===== src/hblank_consts.svh
// Operation
// - bit 7 of blanking-end register ignores writes and reads back as 1
// - skew field bits 6:5 delays start and end of display window
// - skew 00 none, 01 one, 10 two, 11 three character clocks
// - blanking end is 6 bits: register bits 4:0 plus sync-end bit 7
// - sync starts at 8-bit sync-start position counted from active start
// - actual sync start shifts by sync skew field and text mode
// - sync-start register is read/write under group 0 protection
// - protect bit blocks writes to controller indices 0 through 7
// - software writes index port, then accesses register through data port
// - blanking-start value counts clocks from active start to blanking start
`ifndef HBLANK_CONSTS_SVH
`define HBLANK_CONSTS_SVH
`define IO_INDEX_MONO       16'h03B4
`define IO_DATA_MONO        16'h03B5
`define IO_INDEX_COLOR      16'h03D4
`define IO_DATA_COLOR       16'h03D5
`define IDX_BLANK_END       7'h03
`define IDX_SYNC_START      7'h04
`define IDX_PROTECT_LAST    7'h07
`define BLANK_END_RSVD_BIT  7
`define SKEW_HI             6
`define SKEW_LO             5
`define BLANK_END_LO_HI     4
`define IDX_RESET           7'h00
`define BLANK_END_RESET     7'h00
`define SYNC_START_RESET    8'h00
`define HCNT_ZERO           9'h000
`define HCNT_ONE            9'h001
`define TOTAL_ADJUST        9'h004
`define TEXT_SYNC_EXTRA     2'h1
`define BYTE_ZERO           8'h00
`endif

// ===== src/vga_hblank_pkg.sv
package vga_hblank_pkg;
   typedef logic [1:0] skew_t;
   typedef logic [8:0] hcount_t;
   typedef enum logic [1:0] {PORT_NONE, PORT_INDEX, PORT_DATA} port_sel_t;
endpackage

// ===== src/hskew_delay.sv
`timescale 1ns/1ps
`default_nettype none
module hskew_delay
   import vga_hblank_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  din,
   input  wire skew_t amount,
   output logic       dout
);
   logic [3:0] tap_q;
   logic [3:1] tap_d;

   assign tap_q[0] = din;

   genvar g;
   generate
      for (g = 1; g < 4; g++) begin : g_stage
         logic stage_q;
         assign tap_d[g] = tap_q[g-1];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage_q <= 1'b0;
            end else begin
               stage_q <= tap_d[g];
            end
         end
         assign tap_q[g] = stage_q;
      end
   endgenerate

   // 00 passes straight, 11 takes three stages
   always_comb begin
      dout = tap_q[amount];
   end
endmodule // hskew_delay
`default_nettype wire

// ===== sim/hmonitor_model.sv
`timescale 1ns/1ps
`default_nettype none
module hmonitor_model (
   input  wire logic clk,
   input  wire logic display_enable,
   input  wire logic hblank,
   input  wire logic hsync,
   output int        de_t,
   output int        hb_t,
   output int        hs_t,
   output int        hbf_t
);
   int   t = 0;
   logic de_q = 0;
   logic hb_q = 0;
   logic hs_q = 0;

   // stamps the last rising edges and the blanking fall, as a monitor sees them
   always @(posedge clk) begin
      t <= t + 1;
      if (display_enable && !de_q) de_t <= t;
      if (hblank && !hb_q) hb_t <= t;
      if (!hblank && hb_q) hbf_t <= t;
      if (hsync && !hs_q) hs_t <= t;
      de_q <= display_enable;
      hb_q <= hblank;
      hs_q <= hsync;
   end
endmodule // hmonitor_model
`default_nettype wire

// ===== sim/vga_hblank_end_hsync_start_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hblank_consts.svh"
module vga_hblank_end_hsync_start_tb;
   import vga_hblank_pkg::*;
   logic        clk = 0, nrst = 0, io_wr = 0, io_rd = 0, color = 1, group_protect = 0;
   logic        text_mode = 0;
   logic        blank_msb = 1'b1;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0]  io_wdata = 8'h00;
   logic [7:0]  io_rdata;
   skew_t       sync_skew = 2'h0;
   logic        display_enable, hblank, hsync;
   int          de_t, hb_t, hs_t, hbf_t;
   int          err_total = 0, check_count = 0, cyc = 0;

   always #12.5 clk = ~clk;

   // line of 64 chars, blank 40..60, sync from 48
   vga_hblank_end_hsync_start uut (.clk(clk), .nrst(nrst), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .color_port_emulation(color), .group_protect(group_protect),
      .horiz_total(8'h3B), .display_end(8'h27), .horiz_blank_start(8'h28),
      .blank_end_msb(blank_msb), .sync_end_low(5'h18), .sync_skew(sync_skew),
      .text_mode(text_mode), .display_enable(display_enable), .hblank(hblank),
      .hsync(hsync));

   hmonitor_model mon (.clk(clk), .display_enable(display_enable), .hblank(hblank),
      .hsync(hsync), .de_t(de_t), .hb_t(hb_t), .hs_t(hs_t), .hbf_t(hbf_t));

   task automatic summarize;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      #2;
      io_addr = a;
      io_wr = w;
      io_rd = !w;
      io_wdata = d;
      @(posedge clk);
      #2;
      io_wr = 0;
      io_rd = 0;
   endtask

   task automatic wreg(input logic [6:0] i, input logic [7:0] d);
      acc(`IO_INDEX_COLOR, 1'b1, {1'b0, i});
      acc(`IO_DATA_COLOR, 1'b1, d);
   endtask

   task automatic rreg(input logic [6:0] i, input logic [7:0] e);
      acc(`IO_INDEX_COLOR, 1'b1, {1'b0, i});
      acc(`IO_DATA_COLOR, 1'b0, 8'h00);
      chk(io_rdata, e);
   endtask

   // settles a few lines, then stops just after a blanking fall
   task automatic line_done;
      int old;
      repeat (200) @(posedge clk);
      old = hbf_t;
      for (int n = 0; n < 100 && hbf_t == old; n++) @(posedge clk);
      #2;
      chk(8'(hbf_t != old), 8'h01);
   endtask

   task automatic t_regs;
      rreg(`IDX_BLANK_END, 8'h80);
      wreg(`IDX_BLANK_END, 8'h5C);
      rreg(`IDX_BLANK_END, 8'hDC);
      wreg(`IDX_SYNC_START, 8'hA5);
      rreg(`IDX_SYNC_START, 8'hA5);
      rreg(7'h10, 8'h00);
      acc(`IO_INDEX_COLOR, 1'b0, 8'h00);
      chk(io_rdata, 8'h10);
      color = 0;
      wreg(`IDX_SYNC_START, 8'h3C);
      acc(`IO_INDEX_MONO, 1'b1, 8'h04);
      acc(`IO_DATA_MONO, 1'b0, 8'h00);
      chk(io_rdata, 8'hA5);
      color = 1;
      rreg(`IDX_SYNC_START, 8'hA5);
      $display("test regs done, errors %0d", err_total);
   endtask

   task automatic t_protect;
      group_protect = 1;
      wreg(`IDX_SYNC_START, 8'h11);
      wreg(`IDX_BLANK_END, 8'h00);
      rreg(`IDX_SYNC_START, 8'hA5);
      rreg(`IDX_BLANK_END, 8'hDC);
      group_protect = 0;
      $display("test protect done, errors %0d", err_total);
   endtask

   task automatic t_skew;
      wreg(`IDX_SYNC_START, 8'h30);
      for (int k = 0; k < 4; k++) begin
         wreg(`IDX_BLANK_END, {1'b1, 2'(k), 5'h1C});
         line_done;
         chk(8'(hb_t - de_t), 8'h29 - 8'(k));
         chk(8'(hbf_t - hb_t), 8'h14);
      end
      // end value 28 wraps into next line
      blank_msb = 1'b0;
      line_done;
      chk(8'(hbf_t - hb_t), 8'h34);
      blank_msb = 1'b1;
      $display("test skew done, errors %0d", err_total);
   endtask

   task automatic t_sync;
      for (int s = 0; s < 8; s++) begin
         sync_skew = 2'(s);
         text_mode = s[2];
         line_done;
         chk(8'(hs_t - hb_t), 8'h08 + ((s % 4 + s / 4 > 3) ? 8'h03 : 8'(s % 4 + s / 4)));
      end
      $display("test sync done, errors %0d", err_total);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize;
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      #2;
      nrst = 1;
      repeat (3) @(posedge clk);
      t_regs;
      t_protect;
      t_skew;
      t_sync;
      summarize;
   end
endmodule // vga_hblank_end_hsync_start_tb
`default_nettype wire
